// ===== verilog/scd_pkg.sv
// constants, register map and reset values of the sensor compensation datapath
// assumes a single 20 MHz clock and a synchronous active-high reset
// What this block does
// RULE_01: three 8-bit thresholds against source top bits
// RULE_02: rising past first threshold gives 0,1
// RULE_03: rising past second threshold gives 1,0
// RULE_04: rising past third threshold gives 1,1
// RULE_05: steering never active together with alarm mode
// RULE_06: source selectable from four internal points
// RULE_07: filtered temperature 10-bit, right-aligned, bytes 58/59
// RULE_08: signal before linearization 46/47, after 60/61
// RULE_09: analog mode stores digitized gain amplifier output
// RULE_10: four temperature gaps spanning zero to 1023
// RULE_11: three temperature breakpoints select the gap
// RULE_12: gain code is coarse times compensated gain
// RULE_13: first gap uses breakpoint minus temperature
// RULE_14: coefficients 12-bit sign-magnitude, ten fraction bits
// RULE_15: offset adds full spans of earlier gaps
// RULE_16: five signal gaps, first-order around breakpoint
// RULE_17: linearization breakpoints are 10-bit values
// RULE_18: coefficient 1024 leaves output equal to input
// RULE_19: linearization correction accumulates over earlier gaps
// RULE_20: sample and code paths are 10 bits
// RULE_21: codes clamped to 0..1023
package scd_pkg;
    // ==========================================================
    // widths
    localparam int DATA_W = 10; // RULE_20
    localparam int THR_W = 8; // RULE_01
    localparam int COEF_W = 12; // RULE_14
    localparam int FRAC_W = 10; // RULE_14
    localparam int ADDR_W = 8;
    localparam int BUS_W = 16;
    localparam int N_TGAP = 4; // RULE_10
    localparam int N_LGAP = 5; // RULE_16
    localparam logic [9:0] CODE_MAX = 10'h3FF; // RULE_21
    // ==========================================================
    // register offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_LEVEL = 8'h01;
    localparam logic [7:0] OFS_COARSE = 8'h04;
    localparam logic [7:0] OFS_GAIN = 8'h05;
    localparam logic [7:0] OFS_OFFSET = 8'h06;
    localparam logic [7:0] OFS_TBREAK = 8'h08;
    localparam logic [7:0] OFS_GAIN_TEMP_COEFF = 8'h10;
    localparam logic [7:0] OFS_OFFSET_TEMP_COEFF = 8'h14;
    localparam logic [7:0] OFS_LCOEF = 8'h18;
    localparam logic [7:0] OFS_LBREAK = 8'h20;
    localparam logic [7:0] OFS_SIG_IN = 8'h2E; // RULE_08
    localparam logic [7:0] OFS_TEMP = 8'h3A; // RULE_07
    localparam logic [7:0] OFS_SIG_OUT = 8'h3C; // RULE_08
    localparam logic [7:0] OFS_GAIN_DAC = 8'h40;
    localparam logic [7:0] OFS_OFS_DAC = 8'h42;
    localparam logic [7:0] OFS_STATUS = 8'h44;
    // ==========================================================
    // config fields
    localparam int CFG_STEER = 0;
    localparam int CFG_ALARM = 1;
    localparam int CFG_SRC = 2;
    localparam int CFG_ANALOG = 4;
    // ==========================================================
    // reset values
    localparam logic [4:0] RST_CONFIG = 5'h00;
    localparam logic [7:0] RST_LEVEL = 8'hFF;
    localparam logic [2:0] RST_COARSE = 3'h1;
    localparam logic [9:0] RST_GAIN = 10'h000;
    localparam logic [9:0] RST_OFFSET = 10'h000;
    localparam logic [9:0] RST_TBREAK = 10'h3FF;
    localparam logic [11:0] RST_TCOEF = 12'h000;
    localparam logic [11:0] RST_LCOEF = 12'h400; // RULE_18
    localparam logic [9:0] RST_LBREAK = 10'h3FF;
    localparam logic [9:0] RST_LBREAK_FIRST = 10'h000;
endpackage : scd_pkg

// ===== verilog/scd_fx_scale.sv
// sign-magnitude coefficient times signed difference, scaled by the fraction bits
// assumes differences within -1023..1023
`timescale 1ns/100ps
`default_nettype none
module scd_fx_scale (
    input wire logic [scd_pkg::COEF_W-1:0] coef,
    input wire logic signed [10:0] delta,
    output logic signed [13:0] prod
);
    import scd_pkg::*;
    logic [10:0] mag_d;
    logic [21:0] full;
    logic [11:0] q;
    logic neg;
    // ==========================================================
    // magnitude product, truncated toward zero
    assign mag_d = delta[10] ? 11'(-delta) : 11'(delta);
    assign full = coef[COEF_W-2:0] * mag_d; // RULE_14
    assign q = full[21:FRAC_W];
    assign neg = coef[COEF_W-1] ^ delta[10]; // RULE_14
    assign prod = neg ? -$signed({2'b00, q}) : $signed({2'b00, q});
endmodule : scd_fx_scale
`default_nettype wire

// ===== verilog/scd_datapath.sv
// level steering, temperature compensation and signal linearization
// assumes samples come from logic on sys_clk; plain register port
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module scd_datapath (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [scd_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [scd_pkg::BUS_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [scd_pkg::BUS_W-1:0] reg_rdata,
    input wire logic [scd_pkg::DATA_W-1:0] input_amp_out,
    input wire logic [scd_pkg::DATA_W-1:0] gain_amp_out,
    input wire logic [scd_pkg::DATA_W-1:0] temp_amp_out,
    input wire logic [scd_pkg::DATA_W-1:0] voltage_output_node,
    input wire logic [scd_pkg::DATA_W-1:0] signal_adc,
    input wire logic [scd_pkg::DATA_W-1:0] temp_filtered,
    output logic steer_pin_high,
    output logic steer_pin_low,
    output logic steer_oe,
    output logic [scd_pkg::DATA_W-1:0] gain_dac_code,
    output logic [scd_pkg::DATA_W-1:0] offset_dac_code,
    output logic [scd_pkg::DATA_W-1:0] lin_out_code
);
    import scd_pkg::*;
    // ==========================================================
    // register storage
    logic [4:0] config_reg;
    logic [7:0] level_thr [0:2];
    logic [2:0] coarse_gain;
    logic [9:0] fine_gain;
    logic [9:0] fine_offset;
    logic [9:0] temp_break [0:2];
    logic [11:0] gain_temp_coeff [0:3];
    logic [11:0] offset_temp_coeff [0:3];
    logic [11:0] lin_coeff [0:4];
    logic [9:0] lin_breakpoint [0:4];
    logic [9:0] signal_input_sample;
    logic [9:0] filtered_temperature;
    logic steer_on;
    logic [7:0] src8;
    logic [1:0] next_level;
    logic [1:0] tgap;
    logic [2:0] lgap;
    logic signed [10:0] sc_del [0:8];
    logic [11:0] sc_coef [0:8];
    logic signed [13:0] sc_out [0:8];
    logic signed [17:0] gain_sum;
    logic signed [15:0] ofs_sum;
    logic signed [15:0] lin_sum;
    function automatic logic [9:0] clamp10(input logic signed [17:0] v);
        if (v < 0) begin
            return 10'h000;
        end else if (v > 18'sd1023) begin
            return CODE_MAX;
        end else begin
            return v[9:0];
        end
    endfunction : clamp10
    function automatic logic signed [10:0] sdiff(input logic [9:0] a, input logic [9:0] b);
        return $signed({1'b0, a}) - $signed({1'b0, b});
    endfunction : sdiff
    // ==========================================================
    // register writes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            config_reg <= RST_CONFIG;
            coarse_gain <= RST_COARSE;
            fine_gain <= RST_GAIN;
            fine_offset <= RST_OFFSET;
            for (int i = 0; i < 3; i++) begin
                level_thr[i] <= RST_LEVEL;
                temp_break[i] <= RST_TBREAK;
            end
            for (int i = 0; i < N_TGAP; i++) begin
                gain_temp_coeff[i] <= RST_TCOEF;
                offset_temp_coeff[i] <= RST_TCOEF;
            end
            for (int i = 0; i < N_LGAP; i++) begin
                lin_coeff[i] <= RST_LCOEF;
                lin_breakpoint[i] <= (i == 0) ? RST_LBREAK_FIRST : RST_LBREAK;
            end
        end else if (reg_wr) begin
            if (reg_addr == OFS_CONFIG) begin
                config_reg <= reg_wdata[4:0];
            end
            if (reg_addr == OFS_COARSE) begin
                coarse_gain <= reg_wdata[2:0];
            end
            if (reg_addr == OFS_GAIN) begin
                fine_gain <= reg_wdata[9:0];
            end
            if (reg_addr == OFS_OFFSET) begin
                fine_offset <= reg_wdata[9:0];
            end
            for (int i = 0; i < 3; i++) begin
                if (reg_addr == OFS_LEVEL + 8'(i)) begin
                    level_thr[i] <= reg_wdata[7:0]; // RULE_01
                end
                if (reg_addr == OFS_TBREAK + 8'(i)) begin
                    temp_break[i] <= reg_wdata[9:0]; // RULE_11
                end
            end
            for (int i = 0; i < N_TGAP; i++) begin
                if (reg_addr == OFS_GAIN_TEMP_COEFF + 8'(i)) begin
                    gain_temp_coeff[i] <= reg_wdata[11:0];
                end
                if (reg_addr == OFS_OFFSET_TEMP_COEFF + 8'(i)) begin
                    offset_temp_coeff[i] <= reg_wdata[11:0];
                end
            end
            for (int i = 0; i < N_LGAP; i++) begin
                if (reg_addr == OFS_LCOEF + 8'(i)) begin
                    lin_coeff[i] <= reg_wdata[11:0];
                end
                if (reg_addr == OFS_LBREAK + 8'(i)) begin
                    lin_breakpoint[i] <= reg_wdata[9:0]; // RULE_17
                end
            end
        end
    end
    // ==========================================================
    // register reads, data one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= 16'h0000;
            case (reg_addr)
                OFS_CONFIG: reg_rdata <= {11'h000, config_reg};
                OFS_COARSE: reg_rdata <= {13'h0000, coarse_gain};
                OFS_GAIN: reg_rdata <= {6'h00, fine_gain};
                OFS_OFFSET: reg_rdata <= {6'h00, fine_offset};
                OFS_SIG_IN: reg_rdata <= {6'h00, signal_input_sample}; // RULE_08
                OFS_TEMP: reg_rdata <= {6'h00, filtered_temperature}; // RULE_07
                OFS_SIG_OUT: reg_rdata <= {6'h00, lin_out_code}; // RULE_08
                OFS_GAIN_DAC: reg_rdata <= {6'h00, gain_dac_code};
                OFS_OFS_DAC: reg_rdata <= {6'h00, offset_dac_code};
                OFS_STATUS: reg_rdata <= {11'h000, lgap, tgap};
                default: begin
                    for (int i = 0; i < 3; i++) begin
                        if (reg_addr == OFS_LEVEL + 8'(i)) reg_rdata <= {8'h00, level_thr[i]};
                        if (reg_addr == OFS_TBREAK + 8'(i)) reg_rdata <= {6'h00, temp_break[i]};
                    end
                    for (int i = 0; i < N_TGAP; i++) begin
                        if (reg_addr == OFS_GAIN_TEMP_COEFF + 8'(i)) reg_rdata <= {4'h0, gain_temp_coeff[i]};
                        if (reg_addr == OFS_OFFSET_TEMP_COEFF + 8'(i)) reg_rdata <= {4'h0, offset_temp_coeff[i]};
                    end
                    for (int i = 0; i < N_LGAP; i++) begin
                        if (reg_addr == OFS_LCOEF + 8'(i)) reg_rdata <= {4'h0, lin_coeff[i]};
                        if (reg_addr == OFS_LBREAK + 8'(i)) reg_rdata <= {6'h00, lin_breakpoint[i]};
                    end
                end
            endcase
        end
    end
    // ==========================================================
    // sample capture
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            signal_input_sample <= 10'h000;
            filtered_temperature <= 10'h000;
        end else begin
            signal_input_sample <= config_reg[CFG_ANALOG] ? gain_amp_out : signal_adc; // RULE_09
            filtered_temperature <= temp_filtered; // RULE_07
        end
    end
    // ==========================================================
    // level steering
    assign steer_on = config_reg[CFG_STEER] && !config_reg[CFG_ALARM]; // RULE_05
    always_comb begin
        case (config_reg[CFG_SRC+:2]) // RULE_06
            2'h0: src8 = input_amp_out[9:2];
            2'h1: src8 = gain_amp_out[9:2];
            2'h2: src8 = temp_amp_out[9:2];
            default: src8 = voltage_output_node[9:2];
        endcase
        if (src8 >= level_thr[2]) begin
            next_level = 2'h3; // RULE_04
        end else if (src8 >= level_thr[1]) begin
            next_level = 2'h2; // RULE_03
        end else if (src8 >= level_thr[0]) begin
            next_level = 2'h1; // RULE_02
        end else begin
            next_level = 2'h0; // RULE_02
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst || !steer_on) begin
            steer_pin_high <= 1'b0;
            steer_pin_low <= 1'b0;
            steer_oe <= 1'b0;
        end else begin
            steer_pin_high <= next_level[1]; // RULE_01
            steer_pin_low <= next_level[0]; // RULE_01
            steer_oe <= 1'b1; // RULE_05
        end
    end
    // ==========================================================
    // gap selection
    always_comb begin
        if (filtered_temperature < temp_break[0]) begin
            tgap = 2'd0; // RULE_11
        end else if (filtered_temperature < temp_break[1]) begin
            tgap = 2'd1;
        end else if (filtered_temperature < temp_break[2]) begin
            tgap = 2'd2;
        end else begin
            tgap = 2'd3; // RULE_10
        end
        if (signal_input_sample < lin_breakpoint[1]) begin
            lgap = 3'd0; // RULE_16
        end else if (signal_input_sample < lin_breakpoint[2]) begin
            lgap = 3'd1;
        end else if (signal_input_sample < lin_breakpoint[3]) begin
            lgap = 3'd2;
        end else if (signal_input_sample < lin_breakpoint[4]) begin
            lgap = 3'd3;
        end else begin
            lgap = 3'd4;
        end
    end
    // ==========================================================
    // scaling terms: 0 gain, 1 offset, 2-3 offset spans, 4 lin, 5-8 lin spans
    always_comb begin
        if (tgap == 2'd0) begin
            sc_del[0] = sdiff(temp_break[0], filtered_temperature); // RULE_13
        end else begin
            sc_del[0] = sdiff(filtered_temperature, temp_break[tgap - 2'd1]); // RULE_13
        end
        sc_coef[0] = gain_temp_coeff[tgap];
        sc_del[1] = sc_del[0];
        sc_coef[1] = offset_temp_coeff[tgap];
        sc_del[2] = sdiff(temp_break[1], temp_break[0]); // RULE_15
        sc_coef[2] = offset_temp_coeff[1];
        sc_del[3] = sdiff(temp_break[2], temp_break[1]); // RULE_15
        sc_coef[3] = offset_temp_coeff[2];
        sc_del[4] = sdiff(signal_input_sample, lin_breakpoint[lgap]); // RULE_16
        sc_coef[4] = lin_coeff[lgap];
        for (int k = 0; k < 4; k++) begin
            sc_del[5+k] = sdiff(lin_breakpoint[k+1], lin_breakpoint[k]); // RULE_19
            sc_coef[5+k] = lin_coeff[k];
        end
    end
    genvar g;
    generate
        for (g = 0; g < 9; g++) begin : g_scale
            scd_fx_scale u_scale (
                .coef(sc_coef[g]),
                .delta(sc_del[g]),
                .prod(sc_out[g])
            );
        end
    endgenerate
    // ==========================================================
    // sums
    always_comb begin
        gain_sum = 18'($signed({1'b0, coarse_gain}) *
            ($signed({6'h00, fine_gain}) + 16'(sc_out[0]))); // RULE_12
        ofs_sum = $signed({6'h00, fine_offset}) + 16'(sc_out[1]); // RULE_15
        if (tgap >= 2'd2) ofs_sum = ofs_sum + 16'(sc_out[2]);
        if (tgap == 2'd3) ofs_sum = ofs_sum + 16'(sc_out[3]);
        lin_sum = $signed({6'h00, lin_breakpoint[0]}) + 16'(sc_out[4]); // RULE_18
        for (int k = 0; k < 4; k++) begin
            if (3'(k) < lgap) lin_sum = lin_sum + 16'(sc_out[5+k]); // RULE_19
        end
    end
    // ==========================================================
    // converter codes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            gain_dac_code <= 10'h000;
            offset_dac_code <= 10'h000;
            lin_out_code <= 10'h000;
        end else begin
            gain_dac_code <= clamp10(gain_sum); // RULE_21
            offset_dac_code <= clamp10(18'(ofs_sum)); // RULE_21
            if (config_reg[CFG_ANALOG]) begin
                lin_out_code <= signal_input_sample; // RULE_09
            end else begin
                lin_out_code <= clamp10(18'(lin_sum)); // RULE_21
            end
        end
    end
    // ==========================================================
    // assertions
    property p_lvl_zero;
        @(posedge sys_clk) disable iff (rst)
        (steer_on && src8 < level_thr[0]) |=> {steer_pin_high, steer_pin_low} == 2'b00;
    endproperty
    a_lvl_zero: assert property (p_lvl_zero) else $error("level not 00"); // RULE_02
    property p_lvl_two;
        @(posedge sys_clk) disable iff (rst)
        (steer_on && src8 >= level_thr[1] && src8 < level_thr[2])
            |=> {steer_pin_high, steer_pin_low} == 2'b10;
    endproperty
    a_lvl_two: assert property (p_lvl_two) else $error("level not 10"); // RULE_03
    property p_lvl_three;
        @(posedge sys_clk) disable iff (rst)
        (steer_on && src8 >= level_thr[2]) |=> {steer_pin_high, steer_pin_low} == 2'b11;
    endproperty
    a_lvl_three: assert property (p_lvl_three) else $error("level not 11"); // RULE_04
    property p_alarm_excl;
        @(posedge sys_clk) disable iff (rst)
        config_reg[CFG_ALARM] |=> !steer_oe && !steer_pin_high && !steer_pin_low;
    endproperty
    a_alarm_excl: assert property (p_alarm_excl) else $error("steering with alarm"); // RULE_05
    property p_analog_in;
        @(posedge sys_clk) disable iff (rst)
        config_reg[CFG_ANALOG] |=> signal_input_sample == $past(gain_amp_out);
    endproperty
    a_analog_in: assert property (p_analog_in) else $error("analog sample wrong"); // RULE_09
    property p_temp_read;
        @(posedge sys_clk) disable iff (rst)
        (reg_rd && reg_addr == OFS_TEMP) |=> reg_rdata == {6'h00, $past(filtered_temperature)};
    endproperty
    a_temp_read: assert property (p_temp_read) else $error("temperature read wrong"); // RULE_07
    property p_tgap_first;
        @(posedge sys_clk) disable iff (rst)
        (filtered_temperature < temp_break[0]) |-> tgap == 2'd0 && !sc_del[0][10];
    endproperty
    a_tgap_first: assert property (p_tgap_first) else $error("first gap wrong"); // RULE_13
    property p_gain_clamp;
        @(posedge sys_clk) disable iff (rst)
        (gain_sum < 0) |=> gain_dac_code == 10'h000;
    endproperty
    a_gain_clamp: assert property (p_gain_clamp) else $error("gain not clamped"); // RULE_21
    property p_unity;
        @(posedge sys_clk) disable iff (rst)
        (!config_reg[CFG_ANALOG] && lin_coeff[0] == RST_LCOEF && lin_breakpoint[0] == 10'h000
            && lgap == 3'd0) |=> lin_out_code == $past(signal_input_sample);
    endproperty
    a_unity: assert property (p_unity) else $error("unity gain not identity"); // RULE_18
    c_steer_top: cover property (@(posedge sys_clk) disable iff (rst) steer_oe && steer_pin_high
        && steer_pin_low);
    c_tgap_last: cover property (@(posedge sys_clk) disable iff (rst) tgap == 2'd3);
    c_lgap_last: cover property (@(posedge sys_clk) disable iff (rst) lgap == 3'd4);
endmodule : scd_datapath
`default_nettype wire

// ===== test/scd_front_end.sv
// behavioural analog front end feeding digitized points to the datapath
// assumes stimulus levels change right after a rising sys_clk edge
`timescale 1ns/100ps
`default_nettype none
module scd_front_end (
    input wire logic sys_clk,
    input wire logic [9:0] sig_set,
    input wire logic [9:0] temp_set,
    output logic [9:0] input_amp_out,
    output logic [9:0] gain_amp_out,
    output logic [9:0] temp_amp_out,
    output logic [9:0] voltage_output_node,
    output logic [9:0] signal_adc,
    output logic [9:0] temp_filtered
);
    // ==========================================================
    // one conversion per clock, gain amplifier point halved, output node point quartered
    always_ff @(posedge sys_clk) begin
        input_amp_out <= sig_set;
        gain_amp_out <= {1'b0, sig_set[9:1]};
        temp_amp_out <= temp_set;
        voltage_output_node <= {2'b00, sig_set[9:2]};
        signal_adc <= sig_set;
        temp_filtered <= temp_set;
    end
endmodule : scd_front_end
`default_nettype wire

// ===== test/tb_top.sv
// register-level tests of the compensation datapath
// assumes scd_pkg compiled first and the front end model beside it
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import scd_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata, rd_val;
    logic [9:0] sig_set = 10'h000;
    logic [9:0] temp_set = 10'h000;
    logic [9:0] ia, ga, ta, vo, sa, tf, gcode, ocode, lcode;
    logic sh, sl, soe;
    int err_total = 0;
    int num_checks = 0;
    int tb_t[3] = '{10'h100, 10'h200, 10'h300};
    int tt[5] = '{10'h000, 10'h080, 10'h100, 10'h280, 10'h3FF};
    int lp[5] = '{10'h010, 10'h100, 10'h200, 10'h300, 10'h3FF};
    int ss[5] = '{10'h005, 10'h180, 10'h280, 10'h380, 10'h3FF};
    logic [11:0] gtc[4] = '{12'h400, 12'hC00, 12'h200, 12'h800};
    logic [11:0] otc[4] = '{12'hC00, 12'h200, 12'hC00, 12'h400};
    logic [11:0] lc[5] = '{12'h400, 12'h200, 12'h600, 12'hC00, 12'h400};
    logic [7:0] st[8] = '{8'h3F, 8'h40, 8'h7F, 8'h80, 8'hBF, 8'hC0, 8'h7F, 8'h3F};
    logic [1:0] sx[8] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h1, 2'h0};
    logic [1:0] srcx[4] = '{2'h2, 2'h1, 2'h3, 2'h0};
    // ==========================================================
    // clock, design and front end
    initial forever #25 sys_clk = ~sys_clk;
    scd_front_end u_front (.sys_clk(sys_clk), .sig_set(sig_set), .temp_set(temp_set),
        .input_amp_out(ia), .gain_amp_out(ga), .temp_amp_out(ta),
        .voltage_output_node(vo), .signal_adc(sa), .temp_filtered(tf));
    scd_datapath dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .input_amp_out(ia), .gain_amp_out(ga), .temp_amp_out(ta), .voltage_output_node(vo),
        .signal_adc(sa), .temp_filtered(tf), .steer_pin_high(sh), .steer_pin_low(sl),
        .steer_oe(soe), .gain_dac_code(gcode), .offset_dac_code(ocode), .lin_out_code(lcode));
    // ==========================================================
    // bus cycles, checks and expected values
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask : rd
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic drive(input logic [9:0] s, input logic [9:0] t);
        @(posedge sys_clk);
        sig_set <= s;
        temp_set <= t;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : drive
    function automatic int fx(input logic [11:0] c, input int d);
        int p;
        p = (int'(c[10:0]) * ((d < 0) ? -d : d)) >>> 10;
        return (c[11] ^ (d < 0)) ? -p : p;
    endfunction : fx
    function automatic logic [15:0] clampc(input int v);
        return (v < 0) ? 16'h0000 : (v > 1023) ? 16'h03FF : 16'(v);
    endfunction : clampc
    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        print_verdict();
    end
    // ==========================================================
    // test sequence
    initial begin
        int g, d, e;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        rd(OFS_CONFIG, rd_val);
        chk(rd_val, 16'h0000);
        rd(OFS_LEVEL, rd_val);
        chk(rd_val, 16'h00FF);
        rd(8'(OFS_LCOEF + 2), rd_val);
        chk(rd_val, 16'h0400);
        rd(OFS_LBREAK, rd_val);
        chk(rd_val, 16'h0000);
        rd(8'h7F, rd_val);
        chk(rd_val, 16'h0000);
        for (int i = 0; i < 3; i++) wr(8'(OFS_LEVEL + i), 16'(64 * (i + 1)));
        wr(OFS_CONFIG, 16'h0001);
        for (int i = 0; i < 8; i++) begin
            drive({st[i], 2'h3}, 10'h000);
            chk(16'({sh, sl}), 16'(sx[i]));
        end
        chk(16'(soe), 16'h0001);
        drive(10'h2FC, 10'h3FF);
        for (int s = 0; s < 4; s++) begin
            wr(OFS_CONFIG, 16'(1 + 4 * s));
            drive(10'h2FC, 10'h3FF);
            chk(16'({sh, sl}), 16'(srcx[s]));
        end
        wr(OFS_CONFIG, 16'h0003);
        drive(10'h2FC, 10'h3FF);
        chk(16'(soe), 16'h0000);
        wr(OFS_CONFIG, 16'h0000);
        wr(OFS_COARSE, 16'h0002);
        wr(OFS_GAIN, 16'h0100);
        wr(OFS_OFFSET, 16'h0080);
        for (int i = 0; i < 3; i++) wr(8'(OFS_TBREAK + i), 16'(tb_t[i]));
        for (int i = 0; i < 4; i++) wr(8'(OFS_GAIN_TEMP_COEFF + i), 16'(gtc[i]));
        for (int i = 0; i < 4; i++) wr(8'(OFS_OFFSET_TEMP_COEFF + i), 16'(otc[i]));
        for (int i = 0; i < 5; i++) begin
            drive(10'h000, 10'(tt[i]));
            g = (tt[i] < tb_t[0]) ? 0 : (tt[i] < tb_t[1]) ? 1 : (tt[i] < tb_t[2]) ? 2 : 3;
            d = (g == 0) ? tb_t[0] - tt[i] : tt[i] - tb_t[g - 1];
            chk(16'(gcode), clampc(2 * (256 + fx(gtc[g], d))));
            e = 128 + fx(otc[g], d) + ((g >= 2) ? fx(otc[1], 256) : 0);
            e = e + ((g == 3) ? fx(otc[2], 256) : 0);
            chk(16'(ocode), clampc(e));
            rd(OFS_TEMP, rd_val);
            chk(rd_val, 16'(tt[i]));
        end
        wr(OFS_GAIN_TEMP_COEFF, 16'h0FFF);
        drive(10'h000, 10'h000);
        chk(16'(gcode), 16'h0000);
        drive(10'h123, 10'h000);
        chk(16'(lcode), 16'h0123);
        for (int i = 0; i < 5; i++) wr(8'(OFS_LBREAK + i), 16'(lp[i]));
        for (int i = 0; i < 5; i++) wr(8'(OFS_LCOEF + i), 16'(lc[i]));
        wr(OFS_SIG_OUT, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            drive(10'(ss[i]), 10'h000);
            g = 0;
            for (int k = 1; k < 5; k++) if (ss[i] >= lp[k]) g = k;
            e = lp[0] + fx(lc[g], ss[i] - lp[g]);
            for (int k = 0; k < g; k++) e = e + fx(lc[k], lp[k + 1] - lp[k]);
            chk(16'(lcode), clampc(e));
            rd(OFS_SIG_IN, rd_val);
            chk(rd_val, 16'(ss[i]));
            rd(OFS_SIG_OUT, rd_val);
            chk(rd_val, clampc(e));
        end
        wr(OFS_CONFIG, 16'h0010);
        drive(10'h2FC, 10'h000);
        chk(16'(lcode), 16'h017E);
        rd(OFS_SIG_IN, rd_val);
        chk(rd_val, 16'h017E);
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
